// file: rtl/cbas_bank.sv
// Purpose: Extended attribute and restricted fault syndrome registers of one bank
// Assumes: Register port strobes are single cycle, read data follows one cycle later
// Notes:   Translation config outputs are registered; fault capture has priority
`default_nettype none
// Overview of operation
// [RL1] Wide VM tag reads zero, ignores writes unless enabled and supported.
// [RL2] With wide tag enabled, VM tag comes from wide field not 8-bit one.
// [RL3] Wide VM tags usable regardless of wide address select.
// [RL4] Bit 1 selects monitor bank; monitor bank uses no tags for TLB.
// [RL5] Monitor select ignored if 32-bit, type not 01, or bank non-secure.
// [RL6] Software must not set hypervisor flag and monitor select on secure bank.
// [RL7] Without two security states, monitor select reads zero, ignores writes.
// [RL8] Bit 0 selects 32-bit v7 formats or 64-bit v8 long format.
// [RL9] 32-bit banks pick format by long format enable; hypervisor ignores bit 0.
// [RL10] 64-bit-only implementation may make wide address select read one.
// [RL11] With 32-bit translation supported, wide address select resets to zero.
// [RL12] Security state change leaves wide address select unknown.
// [RL13] A bank fault records syndrome into the restricted syndrome register.
// [RL14] Syndrome content unknown when translation operation fault flag set.
// [RL15] Descriptor index captured in bits 31:16, unimplemented bits read zero.
// [RL16] Descriptor index visible only to secure accesses.
// [RL17] Without descriptor registers, descriptor index may be unknown.
// [RL18] Source tag captured in bits 15:0, unimplemented bits read zero.
// [RL19] Reserved bits 15:2 of extended attribute read zero, ignore writes.
module cbas_bank
   import cbas_pkg::*;
#(
   parameter bit          WIDE_TAG_SUPPORTED = 1'b1,
   parameter bit          TWO_SEC_STATES     = 1'b1,
   parameter bit          ONLY_64BIT         = 1'b0,
   parameter bit          SEC_DESC_REGS      = 1'b1,
   parameter int unsigned SEC_INDEX_W        = 16,
   parameter int unsigned SRC_TAG_W          = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire cbas_req_s   reg_req,
   output logic [31:0]      reg_rdata,
   input  wire cbas_fault_s fault_in,
   input  wire logic [1:0]  bank_type,
   input  wire logic        bank_secure,
   input  wire logic        hyp_bank,
   input  wire logic [7:0]  primary_vm_tag,
   output cbas_xlat_s       xlat_cfg,
   output logic             irq
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] field_mask(input int unsigned w);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < CBAS_FIELD_W; i++) begin
         if (i < w) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic hit(input cbas_req_s r, input logic [7:0] off);
      return r.addr == off;
   endfunction

   localparam logic [15:0] SEC_IDX_MASK = field_mask(SEC_INDEX_W);
   localparam logic [15:0] SRC_MASK     = field_mask(SRC_TAG_W);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [15:0]         wide_vm_tag_r;
   logic                monitor_bank_select_r;
   logic                wide_address_select_r;
   logic                wide_vm_tag_enable_r;
   logic                long_format_enable_r;
   logic [15:0]         sec_index_r;
   logic [15:0]         src_tag_r;
   logic                syn_unknown_r;
   logic [CBAS_IRQ_W-1:0] irq_stat_r;
   logic [CBAS_IRQ_W-1:0] irq_mask_r;
   logic                bank_secure_r;
   logic [31:0]         rdata_nxt;
   logic                wide_tag_live;
   logic                mon_eff;
   logic                wide_addr_eff;
   logic                sec_change;

   assign wide_tag_live = wide_vm_tag_enable_r && WIDE_TAG_SUPPORTED;
   assign sec_change    = bank_secure != bank_secure_r;
   // Bit 0 is forced high when only the 64-bit format exists
   assign wide_addr_eff = ONLY_64BIT ? 1'b1 : wide_address_select_r; // [RL10]
   // Monitor select only counts on a secure 64-bit stage-1 bank
   assign mon_eff = monitor_bank_select_r && wide_addr_eff
                    && (bank_type == CBAS_TYPE_S1) && bank_secure; // [RL5]

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wide_vm_tag_enable_r <= 1'b0;
         long_format_enable_r <= 1'b0;
      end else if (reg_req.wr && hit(reg_req, CBAS_OFF_CTRL)) begin
         wide_vm_tag_enable_r <= reg_req.wdata[CBAS_CTL_WVT_EN_BIT];
         long_format_enable_r <= reg_req.wdata[CBAS_CTL_LFE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Extended attribute register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wide_vm_tag_r <= CBAS_ATTR_RST[31:16];
      end else if (!wide_tag_live) begin
         wide_vm_tag_r <= 16'h0000; // [RL1]
      end else if (reg_req.wr && hit(reg_req, CBAS_OFF_ATTR_EXT)) begin
         wide_vm_tag_r <= reg_req.wdata[CBAS_HI_LSB +: CBAS_FIELD_W]; // [RL1]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         monitor_bank_select_r <= 1'b0;
      end else if (reg_req.wr && hit(reg_req, CBAS_OFF_ATTR_EXT)) begin
         monitor_bank_select_r <= TWO_SEC_STATES
                                  && reg_req.wdata[CBAS_MON_BIT]; // [RL7]
      end
   end

   // Resets to 32-bit; a security state change is modelled as clearing it,
   // one legal choice of the unknown value, so software must rewrite it.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wide_address_select_r <= CBAS_ATTR_RST[CBAS_WIDE_ADDR_BIT]; // [RL11]
      end else if (sec_change) begin
         wide_address_select_r <= 1'b0; // [RL12]
      end else if (reg_req.wr && hit(reg_req, CBAS_OFF_ATTR_EXT)) begin
         wide_address_select_r <= reg_req.wdata[CBAS_WIDE_ADDR_BIT]; // [RL8]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bank_secure_r <= 1'b0;
      end else begin
         bank_secure_r <= bank_secure;
      end
   end

   // ---------------------------------------------------------------
   // Restricted syndrome register
   // ---------------------------------------------------------------
   // Fault capture beats a simultaneous software write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sec_index_r   <= 16'h0000;
         src_tag_r     <= 16'h0000;
         syn_unknown_r <= 1'b0;
      end else if (fault_in.valid) begin
         sec_index_r   <= SEC_DESC_REGS ? (fault_in.sec_index & SEC_IDX_MASK)
                                        : 16'h0000; // [RL13] [RL15] [RL17]
         src_tag_r     <= fault_in.src_tag & SRC_MASK; // [RL13] [RL18]
         syn_unknown_r <= fault_in.op_fault; // [RL14]
      end else if (reg_req.wr && hit(reg_req, CBAS_OFF_SYNDROME)) begin
         if (reg_req.secure) begin
            sec_index_r <= reg_req.wdata[CBAS_HI_LSB +: CBAS_FIELD_W]
                           & SEC_IDX_MASK; // [RL15] [RL16]
         end
         src_tag_r <= reg_req.wdata[CBAS_LO_LSB +: CBAS_FIELD_W] & SRC_MASK; // [RL18]
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status and mask
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_r <= '0;
      end else begin
         for (int i = 0; i < CBAS_IRQ_W; i++) begin
            // Set beats a write-one clear in the same cycle
            if ((i == CBAS_IRQ_FAULT_BIT && fault_in.valid)
                || (i == CBAS_IRQ_SEC_CHG_BIT && sec_change)) begin
               irq_stat_r[i] <= 1'b1;
            end else if (reg_req.wr && hit(reg_req, CBAS_OFF_IRQ_STAT)
                         && reg_req.wdata[i]) begin
               irq_stat_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_r <= '0;
      end else if (reg_req.wr && hit(reg_req, CBAS_OFF_IRQ_MASK)) begin
         irq_mask_r <= reg_req.wdata[CBAS_IRQ_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // ---------------------------------------------------------------
   // Translation configuration
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         xlat_cfg <= '{monitor: 1'b0, use_tags: 1'b1, vm_tag: 16'h0000,
                       fmt: CBAS_FMT_SHORT_V7};
      end else begin
         xlat_cfg.monitor  <= mon_eff; // [RL4]
         xlat_cfg.use_tags <= !mon_eff; // [RL4]
         // Wide tag used regardless of address width
         xlat_cfg.vm_tag   <= wide_tag_live ? wide_vm_tag_r
                              : {8'h00, primary_vm_tag}; // [RL2] [RL3]
         if (hyp_bank) begin
            // Hypervisor banks ignore bit 0 and use the long 32-bit format
            xlat_cfg.fmt <= CBAS_FMT_LONG_V7; // [RL9]
         end else if (wide_addr_eff) begin
            xlat_cfg.fmt <= CBAS_FMT_LONG_V8; // [RL8]
         end else begin
            xlat_cfg.fmt <= long_format_enable_r ? CBAS_FMT_LONG_V7
                                                 : CBAS_FMT_SHORT_V7; // [RL9]
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = CBAS_ZERO;
      case (reg_req.addr)
         CBAS_OFF_ATTR_EXT: begin
            rdata_nxt[CBAS_HI_LSB +: CBAS_FIELD_W] = wide_vm_tag_r; // [RL1]
            rdata_nxt[CBAS_MON_BIT]       = monitor_bank_select_r; // [RL7]
            rdata_nxt[CBAS_WIDE_ADDR_BIT] = wide_addr_eff; // [RL10]
            // Bits 15:2 stay zero
            rdata_nxt[15:2] = 14'h0000; // [RL19]
         end
         CBAS_OFF_SYNDROME: begin
            if (reg_req.secure) begin
               rdata_nxt[CBAS_HI_LSB +: CBAS_FIELD_W] = sec_index_r; // [RL16]
            end
            rdata_nxt[CBAS_LO_LSB +: CBAS_FIELD_W] = src_tag_r;
         end
         CBAS_OFF_CTRL: begin
            rdata_nxt[CBAS_CTL_WVT_EN_BIT] = wide_vm_tag_enable_r;
            rdata_nxt[CBAS_CTL_LFE_BIT]    = long_format_enable_r;
         end
         CBAS_OFF_STATUS: begin
            rdata_nxt[CBAS_ST_MON_EFF_BIT] = mon_eff;
            rdata_nxt[CBAS_ST_UNK_BIT]     = syn_unknown_r; // [RL14]
         end
         CBAS_OFF_IRQ_STAT: rdata_nxt[CBAS_IRQ_W-1:0] = irq_stat_r;
         CBAS_OFF_IRQ_MASK: rdata_nxt[CBAS_IRQ_W-1:0] = irq_mask_r;
         default:           rdata_nxt = CBAS_ZERO;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= CBAS_ZERO;
      end else if (reg_req.rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= CBAS_ZERO;
      end
   end

endmodule
`default_nettype wire

// file: rtl/cbas_pkg.sv
// Purpose: Constants and types for the context bank attribute and syndrome bank
// Assumes: 32-bit register port, one word per register
// Notes:   Offsets are byte addresses
`default_nettype none
package cbas_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CBAS_OFF_ATTR_EXT  = 8'h00;
   localparam logic [7:0] CBAS_OFF_SYNDROME  = 8'h04;
   localparam logic [7:0] CBAS_OFF_CTRL      = 8'h08;
   localparam logic [7:0] CBAS_OFF_STATUS    = 8'h0c;
   localparam logic [7:0] CBAS_OFF_IRQ_STAT  = 8'h10;
   localparam logic [7:0] CBAS_OFF_IRQ_MASK  = 8'h14;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CBAS_WIDE_ADDR_BIT   = 0;
   localparam int CBAS_MON_BIT         = 1;
   localparam int CBAS_HI_LSB          = 16;
   localparam int CBAS_LO_LSB          = 0;
   localparam int CBAS_FIELD_W         = 16;
   // Control register bits
   localparam int CBAS_CTL_WVT_EN_BIT  = 0;
   localparam int CBAS_CTL_LFE_BIT     = 1;
   // Status bits
   localparam int CBAS_ST_MON_EFF_BIT  = 0;
   localparam int CBAS_ST_UNK_BIT      = 1;
   // Interrupt bits
   localparam int CBAS_IRQ_FAULT_BIT   = 0;
   localparam int CBAS_IRQ_SEC_CHG_BIT = 1;
   localparam int CBAS_IRQ_W           = 2;
   // ---------------------------------------------------------------
   // Reset values and encodings
   // ---------------------------------------------------------------
   localparam logic [31:0] CBAS_ATTR_RST  = 32'h0000_0000;
   localparam logic [1:0]  CBAS_TYPE_S1   = 2'h1;
   localparam logic [31:0] CBAS_ZERO      = 32'h0000_0000;

   typedef enum logic [1:0] {
      CBAS_FMT_SHORT_V7,
      CBAS_FMT_LONG_V7,
      CBAS_FMT_LONG_V8
   } cbas_fmt_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
      logic        secure;
   } cbas_req_s;

   typedef struct packed {
      logic        valid;
      logic        op_fault;
      logic [15:0] sec_index;
      logic [15:0] src_tag;
   } cbas_fault_s;

   typedef struct packed {
      logic        monitor;
      logic        use_tags;
      logic [15:0] vm_tag;
      cbas_fmt_e   fmt;
   } cbas_xlat_s;
endpackage
`default_nettype wire

// file: sim/cbas_bank_checker.sv
// Purpose: Port assertions for cbas_bank
// Assumes: Default parameters, full-width syndrome fields
// Notes:   Bound into every cbas_bank instance
`default_nettype none
module cbas_bank_checker
   import cbas_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire cbas_req_s   reg_req,
   input wire logic [31:0] reg_rdata,
   input wire cbas_fault_s fault_in,
   input wire logic [1:0]  bank_type,
   input wire logic        bank_secure,
   input wire logic        hyp_bank,
   input wire cbas_xlat_s  xlat_cfg,
   input wire logic        irq
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   AST_MON_NO_TAGS: assert property (xlat_cfg.monitor |-> !xlat_cfg.use_tags)
      else $error("monitor bank still tags");
   AST_MON_GATED: assert property ((bank_type != CBAS_TYPE_S1 || !bank_secure)
      |=> !xlat_cfg.monitor) else $error("monitor effect not gated");
   AST_HYP_FMT: assert property (hyp_bank |=> xlat_cfg.fmt == CBAS_FMT_LONG_V7)
      else $error("hypervisor bank format wrong");
   AST_MON_FMT: assert property (xlat_cfg.monitor && !$past(hyp_bank)
      |-> xlat_cfg.fmt == CBAS_FMT_LONG_V8) else $error("monitor bank not 64-bit");
   AST_SYN_NS_HIDE: assert property (reg_req.rd && !reg_req.secure
      && reg_req.addr == CBAS_OFF_SYNDROME |=> reg_rdata[31:16] == 16'h0)
      else $error("descriptor index visible to non-secure read");
   AST_ATTR_RSVD: assert property (reg_req.rd && reg_req.addr == CBAS_OFF_ATTR_EXT
      |=> reg_rdata[15:2] == 14'h0) else $error("reserved attribute bits set");
   AST_WIDE_TAG_USE: assert property (reg_req.rd && reg_req.addr == CBAS_OFF_ATTR_EXT
      |=> reg_rdata[31:16] == 16'h0 || reg_rdata[31:16] == xlat_cfg.vm_tag)
      else $error("stored wide tag not in use");
   AST_SYN_CAPTURE: assert property (fault_in.valid && !fault_in.op_fault
      ##1 !(reg_req.wr || fault_in.valid)
      ##1 reg_req.rd && reg_req.secure && reg_req.addr == CBAS_OFF_SYNDROME
      |=> reg_rdata == {$past(fault_in.sec_index, 3), $past(fault_in.src_tag, 3)})
      else $error("syndrome not captured");

   cover property (fault_in.valid);
   cover property ($rose(irq));
   cover property (xlat_cfg.monitor);
endmodule

bind cbas_bank cbas_bank_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .fault_in(fault_in), .bank_type(bank_type),
   .bank_secure(bank_secure), .hyp_bank(hyp_bank), .xlat_cfg(xlat_cfg), .irq(irq));
`default_nettype wire

// file: sim/cbas_bank_tb.sv
// Purpose: Directed bench for cbas_bank
// Assumes: Default parameters
// Notes:   Each scenario task drives one scenario and judges it
`default_nettype none
module cbas_bank_tb
   import cbas_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk    = 1'b0;
   logic        rstn       = 1'b0;
   cbas_req_s   req        = '0;
   cbas_fault_s flt        = '0;
   logic [1:0]  btype      = 2'h1;
   logic        bsec       = 1'b1;
   logic        hyp        = 1'b0;
   logic [7:0]  ptag       = 8'h5a;
   logic [31:0] rdata;
   cbas_xlat_s  xcfg;
   logic        irq;
   int          n_mismatch = 0;
   int          num_checks = 0;

   always #50 sys_clk = ~sys_clk;

   cbas_bank dut (.sys_clk(sys_clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
      .fault_in(flt), .bank_type(btype), .bank_secure(bsec), .hyp_bank(hyp),
      .primary_vm_tag(ptag), .xlat_cfg(xcfg), .irq(irq));

   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic s = 1'b1);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0, secure: s};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic s = 1'b1);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, secure: s};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      @(negedge sys_clk);
      check(rdata, exp);
   endtask
   // Ends on a rising edge so callers may drive inputs right away
   task automatic xchk(input logic m, input logic u, input cbas_fmt_e f, input logic [15:0] t);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check({12'h0, xcfg.monitor, xcfg.use_tags, xcfg.fmt, xcfg.vm_tag}, {12'h0, m, u, f, t});
      @(posedge sys_clk);
   endtask
   task automatic fault(input logic op, input logic [15:0] si, input logic [15:0] st);
      @(posedge sys_clk);
      flt <= '{valid: 1'b1, op_fault: op, sec_index: si, src_tag: st};
      @(posedge sys_clk);
      flt.valid <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rdc(CBAS_OFF_ATTR_EXT, 32'h0);
      rdc(CBAS_OFF_IRQ_STAT, 32'h2);
      wr(CBAS_OFF_IRQ_STAT, 32'h2);
      rdc(CBAS_OFF_IRQ_STAT, 32'h0);
      wr(8'h20, 32'hffff_ffff);
      rdc(8'h20, 32'h0);
   endtask
   task automatic t_attr();
      wr(CBAS_OFF_ATTR_EXT, 32'hffff_ffff);
      rdc(CBAS_OFF_ATTR_EXT, 32'h3);
      xchk(1'b1, 1'b0, CBAS_FMT_LONG_V8, 16'h005a);
      ptag <= 8'h3c;
      xchk(1'b1, 1'b0, CBAS_FMT_LONG_V8, 16'h003c);
      rdc(CBAS_OFF_STATUS, 32'h1);
      wr(CBAS_OFF_CTRL, 32'h1);
      wr(CBAS_OFF_ATTR_EXT, 32'hbeef_0000);
      rdc(CBAS_OFF_ATTR_EXT, 32'hbeef_0000);
      xchk(1'b0, 1'b1, CBAS_FMT_SHORT_V7, 16'hbeef);
      wr(CBAS_OFF_CTRL, 32'h3);
      xchk(1'b0, 1'b1, CBAS_FMT_LONG_V7, 16'hbeef);
      wr(CBAS_OFF_ATTR_EXT, 32'hbeef_0003);
      xchk(1'b1, 1'b0, CBAS_FMT_LONG_V8, 16'hbeef);
      btype <= 2'h2;
      xchk(1'b0, 1'b1, CBAS_FMT_LONG_V8, 16'hbeef);
      btype <= 2'h1;
      wr(CBAS_OFF_ATTR_EXT, 32'hbeef_0001);
      hyp <= 1'b1;
      xchk(1'b0, 1'b1, CBAS_FMT_LONG_V7, 16'hbeef);
      hyp <= 1'b0;
      wr(CBAS_OFF_IRQ_MASK, 32'h2);
      bsec <= 1'b0;
      xchk(1'b0, 1'b1, CBAS_FMT_LONG_V7, 16'hbeef);
      @(negedge sys_clk);
      check({31'h0, irq}, 32'h1);
      rdc(CBAS_OFF_ATTR_EXT, 32'hbeef_0000);
      wr(CBAS_OFF_ATTR_EXT, 32'hbeef_0003, 1'b0);
      xchk(1'b0, 1'b1, CBAS_FMT_LONG_V8, 16'hbeef);
      wr(CBAS_OFF_IRQ_STAT, 32'h2);
      rdc(CBAS_OFF_IRQ_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask
   task automatic t_fault();
      @(posedge sys_clk);
      bsec <= 1'b1;
      wr(CBAS_OFF_IRQ_MASK, 32'h1);
      wr(CBAS_OFF_IRQ_STAT, 32'h3);
      fault(1'b0, 16'h1234, 16'habcd);
      rdc(CBAS_OFF_SYNDROME, 32'h1234_abcd);
      check({31'h0, irq}, 32'h1);
      rdc(CBAS_OFF_SYNDROME, 32'h0000_abcd, 1'b0);
      wr(CBAS_OFF_SYNDROME, 32'hffff_0000, 1'b0);
      rdc(CBAS_OFF_SYNDROME, 32'h1234_0000);
      wr(CBAS_OFF_SYNDROME, 32'h5555_6666);
      rdc(CBAS_OFF_SYNDROME, 32'h5555_6666);
      fault(1'b1, 16'h0, 16'h0);
      rdc(CBAS_OFF_STATUS, 32'h2);
      wr(CBAS_OFF_IRQ_STAT, 32'h1);
      rdc(CBAS_OFF_IRQ_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_attr();
      t_fault();
      final_report();
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
